// File: verilog/lcv_counter_pkg.sv
// constants and types shared by the line code violation counter
// Operation
// - keep a 16-bit running count of framer line code violations since last read
// - reading the upper-byte register clears the whole count; a lone lower read clears only bits 7 down to 0
// - upper-byte register returns count bits 15 down to 8
// - lower-byte register returns count bits 7 down to 0
// - upper then lower read clears the whole counter
package lcv_counter_pkg;

  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned COUNT_W = 16;

  // offsets within one channel's register page
  localparam logic [ADDR_W-1:0] OFF_COUNT_HIGH = 12'h900;
  localparam logic [ADDR_W-1:0] OFF_COUNT_LOW  = 12'h901;

  localparam logic [COUNT_W-1:0] RESET_COUNT = 16'h0000;
  localparam logic [DATA_W-1:0]  RESET_BYTE  = 8'h00;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } rd_req_t;

  typedef enum logic [0:0] {
    ST_LIVE = 1'b0,
    ST_HELD = 1'b1
  } hold_state_t;

endpackage

// File: verilog/violation_tally.sv
// saturating violation tally with whole and low-byte clears
`timescale 1ns/100ps
`default_nettype none
module violation_tally
  import lcv_counter_pkg::*;
#(
  parameter int unsigned WIDTH  = COUNT_W,
  parameter int unsigned LOW_W  = DATA_W
)(
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             inc_i,
  input  wire logic             clr_all_i,
  input  wire logic             clr_low_i,
  output logic [WIDTH-1:0]      count_o
);

  generate
    if (LOW_W == 0 || LOW_W >= WIDTH)
    begin : g_bad_width
      $error("violation_tally: LOW_W must be between 1 and WIDTH-1");
    end
  endgenerate

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] base;

  // a violation in the cycle of a clear is kept: the clear acts first
  always_comb
  begin
    base = count_q;
    if (clr_all_i)
    begin
      base = '0;
    end
    else if (clr_low_i)
    begin
      base = {count_q[WIDTH-1:LOW_W], {LOW_W{1'b0}}};
    end
    count_d = base;
    // saturate rather than wrap so a full count never reads as small
    if (inc_i && (base != {WIDTH{1'b1}}))
    begin
      count_d = base + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count_q <= WIDTH'(RESET_COUNT);
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign count_o = count_q;

endmodule
`default_nettype wire

// File: verilog/lcv_counter.sv
// line code violation counter with clear-on-read byte registers
`timescale 1ns/100ps
`default_nettype none
module lcv_counter
  import lcv_counter_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              violation_i,
  input  wire rd_req_t           rd_req_i,
  output logic [DATA_W-1:0]      rd_data_o,
  output logic                   rd_valid_o
);

  generate
    if (COUNT_W != 2 * DATA_W)
    begin : g_bad_width
      $error("lcv_counter: count must be exactly two register bytes");
    end
    if (OFF_COUNT_HIGH == OFF_COUNT_LOW)
    begin : g_bad_offsets
      $error("lcv_counter: the two byte registers need distinct offsets");
    end
  endgenerate

  function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] off);
    hits = (addr == off);
  endfunction

  logic               rd_high;
  logic               rd_low;
  logic               clr_all;
  logic               clr_low;
  logic [COUNT_W-1:0] count_w;

  hold_state_t        state_q;
  hold_state_t        state_d;
  logic [DATA_W-1:0]  hold_q;
  logic [DATA_W-1:0]  hold_d;
  logic [DATA_W-1:0]  data_q;
  logic [DATA_W-1:0]  data_d;
  logic               valid_q;
  logic               valid_d;

  assign rd_high = rd_req_i.valid && hits(rd_req_i.addr, OFF_COUNT_HIGH);
  assign rd_low  = rd_req_i.valid && hits(rd_req_i.addr, OFF_COUNT_LOW);

  // upper read empties the whole tally; its low byte survives in hold_q
  assign clr_all = rd_high;
  // a lone lower read only clears the low byte of the live tally
  assign clr_low = rd_low && (state_q == ST_LIVE);

  violation_tally #(
    .WIDTH (COUNT_W),
    .LOW_W (DATA_W)
  ) violation_tally_inst (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .inc_i     (violation_i),
    .clr_all_i (clr_all),
    .clr_low_i (clr_low),
    .count_o   (count_w)
  );

  always_comb
  begin
    state_d = state_q;
    hold_d  = hold_q;
    data_d  = RESET_BYTE;
    valid_d = rd_req_i.valid;
    if (rd_high)
    begin
      data_d  = count_w[COUNT_W-1:DATA_W];
      hold_d  = count_w[DATA_W-1:0];
      state_d = ST_HELD;
    end
    else if (rd_low)
    begin
      unique case (state_q)
        ST_HELD:
        begin
          data_d = hold_q;
        end
        ST_LIVE:
        begin
          data_d = count_w[DATA_W-1:0];
        end
      endcase
      hold_d  = RESET_BYTE;
      state_d = ST_LIVE;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= ST_LIVE;
      hold_q  <= RESET_BYTE;
      data_q  <= RESET_BYTE;
      valid_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      hold_q  <= hold_d;
      data_q  <= data_d;
      valid_q <= valid_d;
    end
  end

  assign rd_data_o  = data_q;
  assign rd_valid_o = valid_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_count_increment: assert property (
    (violation_i && !rd_req_i.valid && count_w != 16'hFFFF)
      |=> (count_w == $past(count_w) + 16'h0001))
    else $error("violation not added to count");

  a_count_saturate: assert property (
    (count_w == 16'hFFFF && !rd_req_i.valid) |=> (count_w == 16'hFFFF))
    else $error("full count wrapped");

  a_high_clears: assert property (
    rd_high |=> (count_w == {15'h0000, $past(violation_i)}))
    else $error("upper read did not clear count");

  a_low_clears_live: assert property (
    (rd_low && state_q == ST_LIVE)
      |=> (count_w == {$past(count_w[15:8]), 7'h00, $past(violation_i)}))
    else $error("lower read did not clear low byte");

  a_high_data: assert property (
    rd_high |=> rd_valid_o && (rd_data_o == $past(count_w[15:8])))
    else $error("upper byte returned wrong value");

  a_low_live_data: assert property (
    (rd_low && state_q == ST_LIVE)
      |=> rd_valid_o && (rd_data_o == $past(count_w[7:0])))
    else $error("lower byte returned wrong value");

  a_hold_capture: assert property (
    rd_high |=> (state_q == ST_HELD) && (hold_q == $past(count_w[7:0])))
    else $error("lower byte not captured on upper read");

  a_pair_coherent: assert property (
    (rd_high && !violation_i) ##1 (rd_low && !violation_i && !rd_high)
      |=> (count_w == 16'h0000) && (rd_data_o == $past(count_w[7:0], 2))
          && (state_q == ST_LIVE) && (hold_q == 8'h00))
    else $error("ordered pair did not clear whole counter");

  a_read_timing: assert property (
    rd_req_i.valid |=> rd_valid_o ##1 (rd_valid_o == $past(rd_req_i.valid)))
    else $error("read answer not one cycle after request");

  // unmapped offsets answer zero and leave tally and held byte alone
  a_unmapped_zero: assert property (
    (rd_req_i.valid && !rd_high && !rd_low)
      |=> (rd_data_o == 8'h00) && $stable(hold_q) && $stable(state_q)
          && (count_w == (($past(count_w) == 16'hFFFF) ? 16'hFFFF
              : $past(count_w) + {15'h0000, $past(violation_i)})))
    else $error("unmapped read returned data or altered count");

  // reset is watched with the default disable switched off
  a_reset_quiet: assert property (
    @(posedge clk_i) disable iff (1'b0)
    !reset_n_i |-> !rd_valid_o && (rd_data_o == 8'h00) && (hold_q == 8'h00)
      && (count_w == 16'h0000) && (state_q == ST_LIVE))
    else $error("state not cleared while reset held");

  a_idle_quiet: assert property (
    !rd_req_i.valid |=> !rd_valid_o && (rd_data_o == 8'h00))
    else $error("answer without a read");

  a_answer_needs_read: assert property (
    rd_valid_o |-> $past(rd_req_i.valid))
    else $error("read answer with no request before it");

  a_low_held_data: assert property (
    (rd_low && state_q == ST_HELD)
      |=> rd_valid_o && (rd_data_o == $past(hold_q)))
    else $error("held lower byte not returned");

  a_held_keeps_live: assert property (
    (rd_low && state_q == ST_HELD && count_w != 16'hFFFF)
      |=> (count_w == $past(count_w) + {15'h0000, $past(violation_i)}))
    else $error("held lower read disturbed the live count");

  a_low_releases: assert property (
    rd_low |=> (state_q == ST_LIVE) && (hold_q == 8'h00))
    else $error("lower read left the held byte");

  a_idle_steady: assert property (
    (!rd_req_i.valid && !violation_i)
      |=> $stable(count_w) && $stable(hold_q) && $stable(state_q))
    else $error("count or held byte moved without cause");

  a_violation_kept: assert property (
    (rd_req_i.valid && violation_i) |=> (count_w != 16'h0000))
    else $error("violation lost in a clearing read");

  a_full_reads_ff: assert property (
    (rd_high && count_w == 16'hFFFF) |=> (rd_data_o == 8'hFF))
    else $error("full count did not read as all ones");

  a_hold_idle: assert property (
    (state_q == ST_HELD && !rd_req_i.valid)
      |=> (state_q == ST_HELD) && $stable(hold_q))
    else $error("held byte lost without a read");

  // only the two reads may move the held state
  a_held_entry: assert property (
    ($changed(state_q) && (state_q == ST_HELD)) |-> $past(rd_high))
    else $error("held state entered without upper read");

  a_live_exit: assert property (
    ($changed(state_q) && (state_q == ST_LIVE)) |-> $past(rd_low))
    else $error("held state left without lower read");

endmodule
`default_nettype wire

// File: bench/lcv_counter_test.sv
// self-checking bench for the line code violation counter
`timescale 1ns/100ps
`default_nettype none
module lcv_counter_test;
  import lcv_counter_pkg::*;
  logic               clk_i;
  logic               reset_n_i;
  logic               violation_i;
  rd_req_t            rd_req_i;
  logic [DATA_W-1:0]  rd_data_o;
  logic               rd_valid_o;
  logic [DATA_W-1:0]  exp_q[$];
  logic [COUNT_W-1:0] cnt;
  logic [DATA_W-1:0]  hold;
  logic               held;
  int                 err_count;
  int                 num_checks;
  int                 seed;

  lcv_counter lcv_counter_inst (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .violation_i (violation_i),
    .rd_req_i    (rd_req_i),
    .rd_data_o   (rd_data_o),
    .rd_valid_o  (rd_valid_o)
  );

  always #25 clk_i = ~clk_i;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check_byte(input logic [DATA_W-1:0] got,
                            input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    num_checks++;
    if (got != exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // the count sticks at full scale instead of wrapping
  function automatic logic [COUNT_W-1:0] bump(input logic [COUNT_W-1:0] c);
    bump = (c == 16'hFFFF) ? c : c + 16'h0001;
  endfunction

  // note the expected byte and the clear, then present the read
  task automatic drive(input logic [ADDR_W-1:0] a, input logic v);
    logic [DATA_W-1:0] e;
    e = RESET_BYTE;
    if (a == OFF_COUNT_HIGH)
    begin
      e = cnt[15:8];
      hold = cnt[7:0];
      held = 1'b1;
      cnt = RESET_COUNT;
    end
    else if (a == OFF_COUNT_LOW)
    begin
      e = held ? hold : cnt[7:0];
      if (!held)
        cnt[7:0] = 8'h00;
      held = 1'b0;
    end
    // a violation coinciding with the clearing read must survive
    if (v)
      cnt = bump(cnt);
    rd_req_i.valid = 1'b1;
    rd_req_i.addr = a;
    violation_i = v;
    exp_q.push_back(e);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic v);
    @(negedge clk_i);
    drive(a, v);
    @(negedge clk_i);
    rd_req_i.valid = 1'b0;
    violation_i = 1'b0;
  endtask

  // upper and lower reads on consecutive edges
  task automatic rd_pair(input logic v);
    @(negedge clk_i);
    drive(OFF_COUNT_HIGH, v);
    @(negedge clk_i);
    drive(OFF_COUNT_LOW, 1'b0);
    @(negedge clk_i);
    rd_req_i.valid = 1'b0;
    violation_i = 1'b0;
  endtask

  task automatic pulse(input int k);
    repeat (k)
    begin
      @(negedge clk_i);
      violation_i = 1'b1;
      cnt = bump(cnt);
    end
    @(negedge clk_i);
    violation_i = 1'b0;
  endtask

  // answers are registered, so sampling on the falling edge is settled
  always @(negedge clk_i)
  begin
    if (rd_valid_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        check_count(1, 0);
      else
        check_byte(rd_data_o, exp_q.pop_front());
    end
    else
    begin
      check_byte(rd_data_o, RESET_BYTE);
    end
  end

  initial
  begin
    #5000000;
    err_count++;
    complete_run();
  end

  initial
  begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    violation_i = 1'b0;
    rd_req_i = '0;
    cnt = RESET_COUNT;
    hold = RESET_BYTE;
    held = 1'b0;
    err_count = 0;
    num_checks = 0;
    seed = $urandom(7484);
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    rd(OFF_COUNT_HIGH, 1'b0);
    rd(OFF_COUNT_LOW, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      pulse($urandom_range(1, 700));
      rd(OFF_COUNT_HIGH, i[0]);
      pulse(i + 1);
      rd(OFF_COUNT_LOW, 1'b0);
      rd(OFF_COUNT_HIGH, 1'b0);
      rd(OFF_COUNT_LOW, 1'b0);
      pulse(i + 2);
      rd_pair(i[1]);
    end
    pulse(4660);
    rd(OFF_COUNT_LOW, 1'b1);
    rd(OFF_COUNT_HIGH, 1'b0);
    rd(OFF_COUNT_LOW, 1'b0);
    rd(12'h9FF, 1'b0);
    rd(OFF_COUNT_LOW, 1'b0);
    // run past full scale: the count must stick at its top
    pulse(65540);
    rd_pair(1'b0);
    pulse(3);
    rd(OFF_COUNT_HIGH, 1'b0);
    pulse(2);
    // a mid-run reset must drop both the tally and the held byte
    @(negedge clk_i);
    reset_n_i = 1'b0;
    cnt = RESET_COUNT;
    hold = RESET_BYTE;
    held = 1'b0;
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    rd(OFF_COUNT_LOW, 1'b0);
    repeat (3) @(negedge clk_i);
    check_count(exp_q.size(), 0);
    complete_run();
  end
endmodule
`default_nettype wire
